//--- mpp_top.sv
// mac-facing mii port: nibble clocks, transmit capture, receive drive,
// carrier and collision, management pin handling, reference forwarding
// assumes the decoder core runs on the core clock; mac pins and the
// management clock are asynchronous and are synchronised here
`default_nettype none
// Summary of operation
// RULE1: station keeps management clock at most 25 mhz
// RULE2: management clock is asynchronous, synchronised here
// RULE3: only one side drives management data
// RULE4: transmit clock follows link speed
// RULE5: mac asserts enable only with valid data
// RULE6: mac sends one nibble per transmit clock
// RULE7: receive clock follows speed, aligned to line
// RULE8: receive nibbles valid only with data valid
// RULE9: receive error flagged only inside packets
// RULE10: carrier sense high while receive medium busy
// RULE11: full duplex keeps collision low
// RULE12: half duplex collision when both media busy
// RULE13: system supplies 25 mhz reference, 50 ppm
// RULE14: mii mode forwards reference clock out
// RULE15: 25 mhz at 100 mb/s, 2.5 at 10; divider gives 20 mhz at 100 mb/s from the 40 mhz core clock
module mpp_top (
  input  wire logic             clock,                 // core clock
  input  wire logic             rstn,                  // sync reset, active low
  input  wire logic             link_fast,             // link at 100 mb/s
  input  wire logic             full_duplex,           // link in full duplex
  input  wire logic             mii_mode,              // mii interface selected
  input  wire mpp_pkg::mpp_rx_s rx_line,               // decoder output
  output var  mpp_pkg::mpp_tx_s tx_out,                // captured transmit nibble
  input  wire logic             mii_tx_en,             // mac transmit enable pin
  input  wire logic [3:0]       mii_txd,               // mac transmit data pins
  output var  logic             mii_tx_clk,            // transmit clock pin
  output var  logic             mii_rx_clk,            // receive clock pin
  output var  logic [3:0]       mii_rxd,               // receive data pins
  output var  logic             mii_rx_dv,             // receive data valid pin
  output var  logic             mii_rx_er,             // receive error pin
  output var  logic             mii_crs,               // carrier sense pin
  output var  logic             mii_col,               // collision pin
  input  wire logic             mdc,                   // management clock pin
  input  wire logic             mdio_i,                // management data in
  output var  logic             mdio_o,                // management data out
  output var  logic             mdio_oe,               // management drive enable
  output var  logic             mgmt_rise,             // management clock rose
  output var  logic             mgmt_bit,              // data sampled at that rise
  input  wire mpp_pkg::mpp_mdo_s mdo_req,              // drive request from engine
  input  wire logic             ref_clock_in,          // reference clock pin
  output var  logic             ref_clock_forward_out, // forwarded reference
  output var  logic             crystal_drive_out      // crystal drive
);
  import mpp_pkg::*;

  // synchroniser stages for pins from other domains
  logic       mdc_s1_q, mdc_s2_q, mdc_s3_q;   // management clock
  logic       mdio_s1_q, mdio_s2_q;           // management data
  logic       txen_s1_q, txen_s2_q;           // transmit enable
  logic [3:0] txd_s1_q, txd_s2_q;             // transmit data
  logic       ref_s1_q, ref_s2_q;             // reference clock
  // edge history of the generated clocks
  logic       txc_prev_q, rxc_prev_q;
  logic       busy_prev_q;                    // receive busy one cycle ago
  logic       tx_busy_q;                      // transmit medium busy

  // decoded events
  wire        mdc_rise_w;  // management clock rising edge
  wire        tx_fall_w;   // transmit clock falling edge
  wire        rx_fall_w;   // receive clock falling edge
  wire        rx_start_w;  // carrier just arrived
  wire        col_d;       // collision next value
  wire        rx_idle_w;   // no packet in progress

  assign mdc_rise_w = mdc_s2_q & ~mdc_s3_q;          // RULE2
  assign tx_fall_w  = txc_prev_q & ~mii_tx_clk;
  assign rx_fall_w  = rxc_prev_q & ~mii_rx_clk;
  assign rx_start_w = rx_line.busy & ~busy_prev_q & ~rx_line.dv;
  assign rx_idle_w  = ~rx_line.dv;
  assign col_d      = ~full_duplex & tx_busy_q & rx_line.busy; // RULE11 RULE12

  // transmit clock generator
  mpp_clkdiv u_txdiv (
    .clock   (clock),
    .rstn    (rstn),
    .fast    (link_fast),
    .restart (1'b0),
    .clk_q   (mii_tx_clk)
  );

  // receive clock, phase restarted when receive carrier arrives
  mpp_clkdiv u_rxdiv (
    .clock   (clock),
    .rstn    (rstn),
    .fast    (link_fast),
    .restart (rx_start_w), // RULE7
    .clk_q   (mii_rx_clk)
  );

  // pin synchronisers, two stages each, a third on the management clock for edge finding
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mdc_s1_q  <= 1'b0;
      mdc_s2_q  <= 1'b0;
      mdc_s3_q  <= 1'b0;
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
      txen_s1_q <= 1'b0;
      txen_s2_q <= 1'b0;
      txd_s1_q  <= 4'h0;
      txd_s2_q  <= 4'h0;
      ref_s1_q  <= 1'b0;
      ref_s2_q  <= 1'b0;
    end else begin
      mdc_s1_q  <= mdc;
      mdc_s2_q  <= mdc_s1_q;
      mdc_s3_q  <= mdc_s2_q;
      mdio_s1_q <= mdio_i;
      mdio_s2_q <= mdio_s1_q;
      txen_s1_q <= mii_tx_en;
      txen_s2_q <= txen_s1_q;
      txd_s1_q  <= mii_txd;
      txd_s2_q  <= txd_s1_q;
      ref_s1_q  <= ref_clock_in;
      ref_s2_q  <= ref_s1_q;
    end
  end

  // edge history
  always_ff @(posedge clock) begin
    if (!rstn) begin
      txc_prev_q  <= 1'b0;
      rxc_prev_q  <= 1'b0;
      busy_prev_q <= 1'b0;
    end else begin
      txc_prev_q  <= mii_tx_clk;
      rxc_prev_q  <= mii_rx_clk;
      busy_prev_q <= rx_line.busy;
    end
  end

  // transmit capture mid-cycle, away from the mac's launch edge
  always_ff @(posedge clock) begin
    if (!rstn) begin
      tx_out    <= '0;
      tx_busy_q <= 1'b0;
    end else if (tx_fall_w) begin
      tx_out    <= '{valid: 1'b1, en: txen_s2_q, nib: txd_s2_q}; // RULE5 RULE6
      tx_busy_q <= txen_s2_q;
    end else begin
      tx_out.valid <= 1'b0;
    end
  end

  // receive outputs change on the falling edge, mac samples the rising
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mii_rxd   <= 4'h0;
      mii_rx_dv <= 1'b0;
      mii_rx_er <= 1'b0;
    end else if (rx_fall_w) begin
      mii_rxd   <= rx_idle_w ? 4'h0 : rx_line.nib;  // RULE8
      mii_rx_dv <= rx_line.dv;                      // RULE8
      mii_rx_er <= rx_line.dv & rx_line.er;         // RULE9
    end
  end

  // carrier and collision follow the media every cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mii_crs <= 1'b0;
      mii_col <= 1'b0;
    end else begin
      mii_crs <= rx_line.busy; // RULE10
      mii_col <= col_d;        // RULE11 RULE12
    end
  end

  // management pins: sample and launch at the clock's rising edge
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mgmt_rise <= 1'b0;
      mgmt_bit  <= 1'b0;
      mdio_o    <= 1'b0;
      mdio_oe   <= 1'b0;
    end else begin
      mgmt_rise <= mdc_rise_w;
      if (mdc_rise_w) begin
        mgmt_bit <= mdio_s2_q;
        mdio_o   <= mdo_req.dat;
        mdio_oe  <= mdo_req.oe; // RULE3
      end
    end
  end

  // reference forwarding and crystal drive
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ref_clock_forward_out <= 1'b0;
      crystal_drive_out     <= 1'b0;
    end else begin
      ref_clock_forward_out <= mii_mode & ref_s2_q; // RULE14
      crystal_drive_out     <= ~ref_s2_q;
    end
  end

  // checks
  col_fdx_a: assert property (@(posedge clock) disable iff (!rstn) // RULE11
    $past(full_duplex) |-> !mii_col)
    else $error("collision raised in full duplex");
  col_both_a: assert property (@(posedge clock) disable iff (!rstn) // RULE12
    mii_col |-> $past(tx_busy_q && rx_line.busy && !full_duplex))
    else $error("collision without both media busy");
  crs_follow_a: assert property (@(posedge clock) disable iff (!rstn) // RULE10
    ##1 mii_crs == $past(rx_line.busy))
    else $error("carrier sense does not follow medium");
  rxd_idle_a: assert property (@(posedge clock) disable iff (!rstn) // RULE8
    !mii_rx_dv |-> mii_rxd == 4'h0)
    else $error("receive data driven outside packet");
  rxer_pkt_a: assert property (@(posedge clock) disable iff (!rstn) // RULE9
    mii_rx_er |-> mii_rx_dv)
    else $error("receive error outside packet");
  rx_stable_a: assert property (@(posedge clock) disable iff (!rstn) // RULE8
    $changed(mii_rxd) |-> $past(rx_fall_w))
    else $error("receive data moved off the falling edge");
  mdio_turn_a: assert property (@(posedge clock) disable iff (!rstn) // RULE3
    $changed(mdio_oe) |-> $past(mdc_rise_w) && mgmt_rise)
    else $error("data line ownership changed off clock edge");
  mdc_pulse_a: assert property (@(posedge clock) disable iff (!rstn) // RULE2
    mgmt_rise |=> !mgmt_rise)
    else $error("management edge strobe longer than one cycle");
  ref_fwd_a: assert property (@(posedge clock) disable iff (!rstn) // RULE14
    $past(!mii_mode) |-> !ref_clock_forward_out)
    else $error("reference forwarded outside mii mode");
  fast_half_a: assert property (@(posedge clock) disable iff (!rstn) // RULE4
    $rose(mii_tx_clk) && link_fast && $past(link_fast) |=> !mii_tx_clk)
    else $error("fast transmit clock half period wrong");

  // scenarios
  col_seen_c: cover property (@(posedge clock) disable iff (!rstn) mii_col);
  rx_err_c: cover property (@(posedge clock) disable iff (!rstn) mii_rx_dv && mii_rx_er);
  tx_cap_c: cover property (@(posedge clock) disable iff (!rstn) tx_out.valid && tx_out.en);
  mdio_drv_c: cover property (@(posedge clock) disable iff (!rstn) $rose(mdio_oe));
endmodule
`default_nettype wire

//--- mpp_pkg.sv
// shared constants and carrier types for the mii port block
// assumes a single 40 mhz core clock drives every register of the block
`default_nettype none
package mpp_pkg;
  // core clock rate
  localparam int CLK_HZ = 40_000_000;
  // nibble clock rates for the two link speeds
  localparam int FAST_HZ = 25_000_000;
  localparam int SLOW_HZ = 2_500_000;
  // management clock ceiling, a limit the station keeps
  localparam int MDC_MAX_HZ = 25_000_000;
  // reference clock expected on the reference pin
  localparam int REF_HZ = 25_000_000;
  localparam int REF_PPM = 50;

  // half period in core cycles, rounded down, never below one
  function automatic int half_cycles(input int hz);
    int n;
    n = CLK_HZ / (2 * hz);
    return (n < 1) ? 1 : n;
  endfunction

  localparam int FAST_HALF = half_cycles(FAST_HZ);
  localparam int SLOW_HALF = half_cycles(SLOW_HZ);
  localparam int CNT_W = 8;

  // receive symbols from the decoder core
  typedef struct packed {
    logic       busy;  // receive medium not idle
    logic       dv;    // nibble belongs to a packet
    logic       er;    // error symbol seen
    logic [3:0] nib;   // decoded nibble
  } mpp_rx_s;

  // transmit nibble handed to the encoder core
  typedef struct packed {
    logic       valid; // one-cycle capture strobe
    logic       en;    // transmit enable as captured
    logic [3:0] nib;   // captured nibble
  } mpp_tx_s;

  // management drive request from the serial engine
  typedef struct packed {
    logic oe;  // device owns the data line
    logic dat; // bit to drive
  } mpp_mdo_s;
endpackage
`default_nettype wire

//--- mpp_clkdiv.sv
// speed-selected nibble clock divider
// assumes fast selects the 100 mb/s rate; restart is a same-clock pulse
`default_nettype none
module mpp_clkdiv (
  input  wire logic clock,   // core clock
  input  wire logic rstn,    // sync reset, active low
  input  wire logic fast,    // requested speed
  input  wire logic restart, // realign phase
  output var  logic clk_q    // divided clock
);
  import mpp_pkg::*;

  localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(FAST_HALF - 1);
  localparam logic [CNT_W-1:0] SLOW_LAST = CNT_W'(SLOW_HALF - 1);

  logic [CNT_W-1:0] cnt_q;  // cycles into this half period
  logic             sel_q;  // speed latched at each edge
  wire              last_w; // half period complete

  // speed only changes on an edge or at restart, so a speed change makes no runt pulse
  assign last_w = (cnt_q == (sel_q ? FAST_LAST : SLOW_LAST));

  // counter and toggle
  always_ff @(posedge clock) begin
    if (!rstn || restart) begin
      cnt_q <= '0;
      clk_q <= 1'b0;
      sel_q <= fast;
    end else if (last_w) begin
      cnt_q <= '0;
      clk_q <= ~clk_q; // RULE4 RULE7
      sel_q <= fast;   // RULE15
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // slow rate holds the high half for the full count
  slow_half_a: assert property (@(posedge clock) disable iff (!rstn || restart) // RULE15
    $rose(clk_q) && !sel_q |-> clk_q[*8] ##1 !clk_q)
    else $error("slow nibble clock half period wrong");
endmodule
`default_nettype wire

//--- mpp_mac_model.sv
// mac and management station model at the far side of the mii port
// assumes the bench resolves the pulled-up data line from both enables
`default_nettype none
module mpp_mac_model (
  input  wire logic       mii_tx_clk, // device transmit clock
  input  wire logic       tx_en_req,  // enable to present
  input  wire logic [3:0] txd_req,    // nibble to present
  input  wire logic       mdio_oe,    // device owns data line
  input  wire logic       mdio_w,     // resolved data line
  output var  logic       mii_tx_en,  // transmit enable pin
  output var  logic [3:0] mii_txd,    // transmit data pins
  output var  logic       mdc,        // management clock, idle low
  output var  logic       st_oe,      // station drives data line
  output var  logic       st_dat,     // station data bit
  output var  logic       seen_bit    // line level at last mdc rise
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet pins at time zero
  initial begin
    mii_tx_en = 1'b0;
    mii_txd = 4'h0;
    mdc = 1'b0;
    st_oe = 1'b0;
    st_dat = 1'b0;
    seen_bit = 1'b0;
  end
  // enable and nibble move together on the transmit clock rise
  always @(posedge mii_tx_clk) begin
    mii_tx_en <= tx_en_req;
    mii_txd <= txd_req;
  end
  // one bit at 5 mhz; clock stands still between bits
  task automatic send_bit(input logic b);
    st_oe = !mdio_oe;
    st_dat = b;
    #100;
    mdc = 1'b1;
    seen_bit = mdio_w;
    #40;
    st_oe = 1'b0;
    #60;
    mdc = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb.sv
// self-checking bench for the mii port block
// assumes the mac model file is compiled first
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mpp_pkg::*;
  logic clock, rstn, link_fast, full_duplex, mii_mode, ref_clock_in;
  logic tx_en_req, mii_tx_en, mdc, st_oe, st_dat, seen_bit, ptx, prx;
  logic [3:0] txd_req, mii_txd, mii_rxd;
  logic mii_tx_clk, mii_rx_clk, mii_rx_dv, mii_rx_er, mii_crs, mii_col;
  logic mdio_o, mdio_oe, mgmt_rise, mgmt_bit, fwd, xdrv;
  mpp_rx_s rx_line;
  mpp_tx_s tx_out;
  mpp_mdo_s mdo_req;
  logic [31:0] seed, r;
  int bad_count, cmp_count, n, f, k;
  wire mdio_w;
  // pulled-up shared line
  assign mdio_w = mdio_oe ? mdio_o : (st_oe ? st_dat : 1'b1);
  mpp_top i_mpp_top (.clock(clock), .rstn(rstn), .link_fast(link_fast),
    .full_duplex(full_duplex), .mii_mode(mii_mode), .rx_line(rx_line), .tx_out(tx_out),
    .mii_tx_en(mii_tx_en), .mii_txd(mii_txd), .mii_tx_clk(mii_tx_clk),
    .mii_rx_clk(mii_rx_clk), .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv),
    .mii_rx_er(mii_rx_er), .mii_crs(mii_crs), .mii_col(mii_col), .mdc(mdc),
    .mdio_i(mdio_w), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mgmt_rise(mgmt_rise),
    .mgmt_bit(mgmt_bit), .mdo_req(mdo_req), .ref_clock_in(ref_clock_in),
    .ref_clock_forward_out(fwd), .crystal_drive_out(xdrv));
  mpp_mac_model i_mpp_mac_model (.mii_tx_clk(mii_tx_clk), .tx_en_req(tx_en_req),
    .txd_req(txd_req), .mdio_oe(mdio_oe), .mdio_w(mdio_w), .mii_tx_en(mii_tx_en),
    .mii_txd(mii_txd), .mdc(mdc), .st_oe(st_oe), .st_dat(st_dat), .seen_bit(seen_bit));
  // 40 mhz core clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // clock history for edge finding
  always @(negedge clock) begin
    ptx <= mii_tx_clk;
    prx <= mii_rx_clk;
  end
  // xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected {col,crs,er,dv,rxd} for a held receive symbol
  function automatic logic [7:0] exp_rx(input mpp_rx_s x, input logic fd, input logic te);
    return {!fd & te & x.busy, x.busy, x.dv & x.er, x.dv, x.dv ? x.nib : 4'h0};
  endfunction
  function automatic logic hit(input int sel);
    case (sel)
      0: return tx_out.valid === 1'b1;
      1: return mgmt_rise === 1'b1;
      2: return mii_tx_clk === 1'b1 && ptx === 1'b0;
      default: return mii_rx_clk === 1'b1 && prx === 1'b0;
    endcase
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // bounded wait, cycles taken in w
  task automatic wait_on(input int sel, output int w);
    for (w = 1; w < 100; w++) begin
      @(negedge clock);
      if (hit(sel)) break;
    end
    if (w == 100) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  initial begin
    seed = 32'h558e;
    {rstn, link_fast, full_duplex, mii_mode, ref_clock_in, tx_en_req} = 6'h00;
    {txd_req, rx_line, mdo_req} = '0;
    {bad_count, cmp_count} = '0;
    repeat (10) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    chk("reset", 8'h01, {3'h0, tx_out.valid, mii_crs, mii_col, mdio_oe, xdrv});
    // both speeds, tx and rx clock periods
    for (f = 1; f >= 0; f--) begin
      link_fast = f[0];
      repeat (3) wait_on(2, n);
      chk("tx period", 8'(2 * (f ? FAST_HALF : SLOW_HALF)), 8'(n));
      repeat (3) wait_on(3, n);
      chk("rx period", 8'(2 * (f ? FAST_HALF : SLOW_HALF)), 8'(n));
    end
    $display("test clocks done");
    for (k = 0; k < 9; k++) begin
      r = rnd();
      tx_en_req = (k == 8) | r[4];
      txd_req = r[3:0];
      repeat (2) wait_on(0, n);
      chk("tx capture", {3'h0, tx_en_req, txd_req}, {3'h0, tx_out.en, tx_out.nib});
    end
    $display("test transmit done");
    for (k = 0; k < 12; k++) begin
      r = rnd();
      rx_line = {r[6] | r[5] | k[0], r[5:0]};
      full_duplex = r[7];
      repeat (2) wait_on(3, n);
      chk("rx pins", exp_rx(rx_line, full_duplex, 1'b1),
        {mii_col, mii_crs, mii_rx_er, mii_rx_dv, mii_rxd});
    end
    $display("test receive done");
    for (k = 0; k < 10; k++) begin
      r = rnd();
      mdo_req = r[1:0];
      fork
        i_mpp_mac_model.send_bit(r[2]);
        wait_on(1, n);
      join
      chk("mgmt", {5'h0, seen_bit, r[1:0]}, {5'h0, mgmt_bit, mdio_oe, mdio_o});
    end
    $display("test management done");
    for (k = 0; k < 4; k++) begin
      mii_mode = k[1];
      ref_clock_in = !k[0];
      repeat (5) @(negedge clock);
      chk("ref", {6'h0, mii_mode & ref_clock_in, !ref_clock_in}, {6'h0, fwd, xdrv});
    end
    $display("test reference done");
    report_and_stop();
  end
endmodule
`default_nettype wire
